// ### hdl/slcr_pkg.sv
// constants and types for the serial lane configuration register bank
package slcr_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 14;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned BE_W      = 4;
  localparam int unsigned IDX_W     = 12;
  localparam int unsigned IDX_LSB   = 2;
  localparam int unsigned BYTE_W    = 8;

  // ----------------------------------------------------------------
  // lane geometry
  // ----------------------------------------------------------------
  localparam int unsigned LANE_CNT  = 8;
  localparam int unsigned CKSUM_CNT = 4;
  localparam int unsigned PARAM_CNT = 12;
  localparam int unsigned SEL_W     = 3;

  typedef logic [BYTE_W-1:0]                slcr_byte_t;
  typedef logic [IDX_W-1:0]                 slcr_idx_t;
  typedef logic [SEL_W-1:0]                 slcr_sel_t;
  typedef logic [PARAM_CNT-1:0][BYTE_W-1:0] slcr_params_t;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam slcr_idx_t IDX_CKSUM0  = 12'h05A0;
  localparam slcr_idx_t IDX_CKSUM1  = 12'h05A1;
  localparam slcr_idx_t IDX_CKSUM2  = 12'h05A2;
  localparam slcr_idx_t IDX_CKSUM3  = 12'h05A3;
  localparam slcr_idx_t IDX_LANE_PD = 12'h05B0;
  localparam slcr_idx_t IDX_XBAR_A  = 12'h05B2;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned XBAR_SEL0_LSB = 0;
  localparam int unsigned XBAR_RSVD_LO  = 3;
  localparam int unsigned XBAR_SEL1_LSB = 4;
  localparam int unsigned XBAR_RSVD_HI  = 7;

  localparam slcr_byte_t CKSUM_RST [CKSUM_CNT] = '{8'hC3, 8'hC4, 8'hC5, 8'hC6};
  localparam slcr_byte_t LANE_PD_RST   = 8'h00;
  localparam slcr_sel_t  XBAR_SEL0_RST = 3'h0;
  localparam slcr_sel_t  XBAR_SEL1_RST = 3'h1;
  localparam slcr_byte_t ONEHOT_BASE   = 8'h01;

  typedef enum logic [0:0] {
    SLCR_IDLE = 1'b0,
    SLCR_ACK  = 1'b1
  } slcr_bus_state_t;

endpackage

// ### hdl/slcr_cks_if.sv
// bundle between the register bank and one lane checksum engine
`timescale 1ns/1ps
`default_nettype none
interface slcr_cks_if;
  import slcr_pkg::*;
  slcr_params_t params;
  slcr_byte_t   lane_id;
  slcr_byte_t   sum;
  modport calc (input params, input lane_id, output sum);
  modport bank (output params, output lane_id, input sum);
endinterface
`default_nettype wire

// ### hdl/slcr_lane_cksum.sv
// one lane checksum engine: registered modulo-256 sum of the lane id and the link parameters
`timescale 1ns/1ps
`default_nettype none
module slcr_lane_cksum
  import slcr_pkg::*;
#(
  parameter slcr_byte_t RST_VAL = CKSUM_RST[0]
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  slcr_cks_if.calc  cif
);

  // ----------------------------------------------------------------
  // adder tree
  // ----------------------------------------------------------------
  slcr_byte_t sum_d;
  slcr_byte_t sum_q;

  // 8-bit accumulator wraps by itself, so no explicit modulo is needed
  always_comb begin
    sum_d = cif.lane_id;
    for (int i = 0; i < PARAM_CNT; i++) begin
      sum_d = sum_d + cif.params[i];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sum_q <= RST_VAL;
    end else if (ce_i) begin
      sum_q <= sum_d;
    end
  end

  assign cif.sum = sum_q;

endmodule
`default_nettype wire

// ### hdl/slcr_top.sv
// serial lane configuration register bank with avalon-mm slave port
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module slcr_top
  import slcr_pkg::*;
(
  input  wire logic         ref_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  input  wire logic [13:0]  avs_address_i,
  input  wire logic         avs_read_i,
  input  wire logic         avs_write_i,
  input  wire logic [31:0]  avs_writedata_i,
  input  wire logic [3:0]   avs_byteenable_i,
  output logic      [31:0]  avs_readdata_o,
  output logic              avs_waitrequest_o,
  input  wire slcr_params_t link_param_i,
  output logic      [7:0]   serial_out_lane_pd_o,
  output logic      [2:0]   phys_lane0_sel_o,
  output logic      [2:0]   phys_lane1_sel_o,
  output logic      [7:0]   phys_lane0_onehot_o,
  output logic      [7:0]   phys_lane1_onehot_o
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  slcr_bus_state_t state_q;
  slcr_bus_state_t state_d;
  slcr_idx_t       acc_idx;
  logic            req;
  logic            aligned;
  logic            take;
  logic            wr_en;
  logic            rd_load;
  logic            hit_pd;
  logic            hit_xbar;
  logic            wr_pd;
  logic            wr_xbar;
  logic [CKSUM_CNT-1:0] hit_cks;
  slcr_byte_t      cks_val [CKSUM_CNT];
  slcr_byte_t      rd_chain [CKSUM_CNT+1];
  slcr_byte_t      rd_byte;
  logic [DATA_W-1:0] rd_word;
  logic [DATA_W-1:0] rdata_q;
  slcr_byte_t      pd_q;
  slcr_byte_t      pd_d;
  slcr_sel_t       sel0_q;
  slcr_sel_t       sel0_d;
  slcr_sel_t       sel1_q;
  slcr_sel_t       sel1_d;
  slcr_byte_t      onehot0_q;
  slcr_byte_t      onehot1_q;
  slcr_byte_t      xbar_rd;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  assign req      = avs_read_i | avs_write_i;
  assign acc_idx  = avs_address_i[ADDR_W-1:IDX_LSB];
  assign aligned  = (avs_address_i[IDX_LSB-1:0] == '0);
  assign hit_pd   = aligned & (acc_idx == IDX_LANE_PD);
  assign hit_xbar = aligned & (acc_idx == IDX_XBAR_A);

  // ----------------------------------------------------------------
  // handshake: one wait state, answer while clock enable is high
  // ----------------------------------------------------------------
  // waitrequest also holds while ce_i is low so a write is never lost
  assign take              = req & ce_i & (state_q == SLCR_ACK);
  assign avs_waitrequest_o = req & ~take;
  assign rd_load           = avs_read_i & ce_i & (state_q == SLCR_IDLE);
  assign wr_en             = take & avs_write_i & avs_byteenable_i[0];
  assign wr_pd             = wr_en & hit_pd;
  assign wr_xbar           = wr_en & hit_xbar;

  always_comb begin
    unique case (state_q)
      SLCR_IDLE: state_d = req ? SLCR_ACK : SLCR_IDLE;
      SLCR_ACK:  state_d = SLCR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SLCR_IDLE;
      rdata_q <= '0;
    end else if (ce_i) begin
      state_q <= state_d;
      if (rd_load) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign avs_readdata_o = rdata_q;

  // ----------------------------------------------------------------
  // checksum engines, one for each of lanes 0 to 3
  // ----------------------------------------------------------------
  assign rd_chain[0] = '0;

  for (genvar k = 0; k < CKSUM_CNT; k++) begin : g_lane
    slcr_cks_if u_cif ();
    assign u_cif.params  = link_param_i;
    assign u_cif.lane_id = slcr_byte_t'(k);
    assign cks_val[k]    = u_cif.sum;
    // consecutive indices from lane 0 upward
    assign hit_cks[k]    = aligned & (acc_idx == slcr_idx_t'(IDX_CKSUM0 + k));
    // no write path reaches the checksum registers
    assign rd_chain[k+1] = rd_chain[k] | (hit_cks[k] ? cks_val[k] : '0);
    slcr_lane_cksum #(
      .RST_VAL (CKSUM_RST[k])
    ) u_cks (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .cif       (u_cif.calc)
    );
  end

  // ----------------------------------------------------------------
  // read mux: unmapped addresses read zero
  // ----------------------------------------------------------------
  // reserved bits 7 and 3 are tied low, not stored
  assign xbar_rd = {1'b0, sel1_q, 1'b0, sel0_q};
  assign rd_byte = rd_chain[CKSUM_CNT]
                 | (hit_pd   ? pd_q    : '0)
                 | (hit_xbar ? xbar_rd : '0);
  assign rd_word = {{(DATA_W-BYTE_W){1'b0}}, rd_byte};

  // ----------------------------------------------------------------
  // lane power-down
  // ----------------------------------------------------------------
  assign pd_d = wr_pd ? avs_writedata_i[BYTE_W-1:0] : pd_q;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pd_q <= LANE_PD_RST;
    end else if (ce_i) begin
      pd_q <= pd_d;
    end
  end

  // bit n drives the power-down of serial_out_laneN
  assign serial_out_lane_pd_o = pd_q;

  // ----------------------------------------------------------------
  // lane crossbar, physical lanes 0 and 1
  // ----------------------------------------------------------------
  assign sel0_d = wr_xbar ? avs_writedata_i[XBAR_SEL0_LSB +: SEL_W] : sel0_q;
  assign sel1_d = wr_xbar ? avs_writedata_i[XBAR_SEL1_LSB +: SEL_W] : sel1_q;

  // one-hot copy is registered beside the field so the route never lags it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel0_q    <= XBAR_SEL0_RST;
      sel1_q    <= XBAR_SEL1_RST;
      onehot0_q <= ONEHOT_BASE << XBAR_SEL0_RST;
      onehot1_q <= ONEHOT_BASE << XBAR_SEL1_RST;
    end else if (ce_i) begin
      sel0_q    <= sel0_d;
      sel1_q    <= sel1_d;
      onehot0_q <= ONEHOT_BASE << sel0_d;
      onehot1_q <= ONEHOT_BASE << sel1_d;
    end
  end

  assign phys_lane0_sel_o    = sel0_q;
  assign phys_lane1_sel_o    = sel1_q;
  assign phys_lane0_onehot_o = onehot0_q;
  assign phys_lane1_onehot_o = onehot1_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking ast_cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  slcr_byte_t ast_param_sum;

  always_comb begin
    ast_param_sum = '0;
    for (int i = 0; i < PARAM_CNT; i++) begin
      ast_param_sum = ast_param_sum + link_param_i[i];
    end
  end

  sequence s_read_done(slcr_idx_t idx);
    avs_read_i && !avs_waitrequest_o && aligned && (acc_idx == idx);
  endsequence

  sequence s_write_done(slcr_idx_t idx);
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && aligned && (acc_idx == idx);
  endsequence

  // reset values stand until the first enabled edge, so sums are checked from then on
  AST_CKSUM_SUM: assert property (
    (ce_i && rst_n_i) |=> (cks_val[2] == slcr_byte_t'($past(ast_param_sum) + 8'h02)))
    else $error("lane 2 checksum is not the parameter sum");

  AST_CKSUM2_READ: assert property (
    (s_read_done(IDX_CKSUM2) and $past(ce_i)) |-> (avs_readdata_o == {24'h00_0000, $past(cks_val[2])}))
    else $error("lane 2 checksum read returns wrong value");

  AST_PD_READ: assert property (
    s_read_done(IDX_LANE_PD) |-> (avs_readdata_o[7:0] == serial_out_lane_pd_o))
    else $error("power-down readback differs from lane outputs");

  AST_PD_WRITE: assert property (
    s_write_done(IDX_LANE_PD) |=> (serial_out_lane_pd_o == $past(avs_writedata_i[7:0])))
    else $error("power-down write did not reach the lanes");

  AST_SEL1_WRITE: assert property (
    s_write_done(IDX_XBAR_A) |=> (phys_lane1_sel_o == $past(avs_writedata_i[6:4])))
    else $error("lane 1 crossbar field not updated");

  AST_ONEHOT: assert property (
    $onehot(phys_lane1_onehot_o) && phys_lane1_onehot_o[phys_lane1_sel_o]
    && $onehot(phys_lane0_onehot_o) && phys_lane0_onehot_o[phys_lane0_sel_o])
    else $error("crossbar route does not match the field");

  AST_XBAR_RSVD: assert property (
    s_read_done(IDX_XBAR_A) |-> (!avs_readdata_o[7] && !avs_readdata_o[3]
                                 && avs_readdata_o[6:4] == phys_lane1_sel_o))
    else $error("crossbar reserved bit reads nonzero");

  AST_CKSUM0_READ: assert property (
    (s_read_done(IDX_CKSUM0) and $past(ce_i)) |-> (avs_readdata_o[7:0] == $past(cks_val[0])))
    else $error("lane 0 checksum read returns wrong value");

  AST_SEL0_WRITE: assert property (
    s_write_done(IDX_XBAR_A) |=> (phys_lane0_sel_o == $past(avs_writedata_i[2:0])))
    else $error("lane 0 crossbar field not updated");

  AST_CKSUM_RO: assert property (
    s_write_done(IDX_CKSUM1) |=> (cks_val[1] == slcr_byte_t'($past(ast_param_sum) + 8'h01)))
    else $error("write disturbed a read-only checksum");

  AST_ONE_WAIT: assert property (
    (req && ce_i && state_q == SLCR_IDLE) |-> avs_waitrequest_o ##1 (!ce_i || !avs_waitrequest_o))
    else $error("slave did not answer after one wait state");

  sequence s_write_stray;
    avs_write_i && !avs_waitrequest_o && (!aligned || !avs_byteenable_i[0]);
  endsequence

  sequence s_read_unmapped;
    avs_read_i && !avs_waitrequest_o && !hit_pd && !hit_xbar && (hit_cks == '0);
  endsequence

  AST_CKSUM0_SUM: assert property (
    (ce_i && rst_n_i) |=> (cks_val[0] == $past(ast_param_sum)))
    else $error("lane 0 checksum is not the parameter sum");

  AST_CKSUM1_SUM: assert property (
    (ce_i && rst_n_i) |=> (cks_val[1] == slcr_byte_t'($past(ast_param_sum) + 8'h01)))
    else $error("lane 1 checksum is not the parameter sum");

  AST_CKSUM3_SUM: assert property (
    (ce_i && rst_n_i) |=> (cks_val[3] == slcr_byte_t'($past(ast_param_sum) + 8'h03)))
    else $error("lane 3 checksum is not the parameter sum");

  AST_RDATA_HI: assert property (
    avs_readdata_o[31:8] == 24'h00_0000)
    else $error("read data above the low byte is nonzero");

  AST_STRAY_WRITE: assert property (
    s_write_stray |=> ($stable(serial_out_lane_pd_o) && $stable(phys_lane0_sel_o)
                       && $stable(phys_lane1_sel_o)))
    else $error("write without byte lane 0 or misaligned changed a register");

  AST_UNMAPPED_READ: assert property (
    s_read_unmapped |-> (avs_readdata_o == 32'h0000_0000))
    else $error("unmapped read returned nonzero data");

  AST_PD_HOLD: assert property (
    !wr_pd |=> $stable(serial_out_lane_pd_o))
    else $error("power-down bits changed without a write");

  AST_XBAR_HOLD: assert property (
    !wr_xbar |=> ($stable(phys_lane0_sel_o) && $stable(phys_lane1_sel_o)))
    else $error("crossbar fields changed without a write");

  AST_IDLE_READY: assert property (
    !req |-> !avs_waitrequest_o)
    else $error("waitrequest high with no request");

  // clock enable low must freeze the handshake, the read word and the lane 1 sum
  AST_CE_FREEZE: assert property (
    !ce_i |=> ($stable(state_q) && $stable(avs_readdata_o) && $stable(cks_val[1])))
    else $error("state moved while clock enable was low");

endmodule
`default_nettype wire

// ### bench/slcr_bench.sv
// self-checking bench for the serial lane configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); end end
module slcr_bench
  import slcr_pkg::*;
();
  logic         ref_clk;
  logic         rst_n;
  logic         ce;
  logic [13:0]  addr;
  logic         rd;
  logic         wr;
  logic [31:0]  wdata;
  logic [3:0]   be;
  logic [31:0]  rdata;
  logic         wait_req;
  slcr_params_t params;
  logic [7:0]   pd;
  logic [2:0]   sel0;
  logic [2:0]   sel1;
  logic [7:0]   hot0;
  logic [7:0]   hot1;
  slcr_byte_t   got;
  slcr_idx_t    idx;
  int           cyc;
  int           i;
  int           n_mismatch;
  int           checks_done;

  slcr_top dut (
    .ref_clk_i           (ref_clk),
    .rst_n_i             (rst_n),
    .ce_i                (ce),
    .avs_address_i       (addr),
    .avs_read_i          (rd),
    .avs_write_i         (wr),
    .avs_writedata_i     (wdata),
    .avs_byteenable_i    (be),
    .avs_readdata_o      (rdata),
    .avs_waitrequest_o   (wait_req),
    .link_param_i        (params),
    .serial_out_lane_pd_o(pd),
    .phys_lane0_sel_o    (sel0),
    .phys_lane1_sel_o    (sel1),
    .phys_lane0_onehot_o (hot0),
    .phys_lane1_onehot_o (hot1)
  );

  always #2 ref_clk = ~ref_clk;

  // ----------------------------------------------------------------
  // bus access
  // ----------------------------------------------------------------
  // a stuck waitrequest is left to the watchdog, the master never gives up by itself
  task automatic bus_xfer(input logic is_wr, input slcr_idx_t ix, input logic [1:0] lo,
                          input slcr_byte_t d, input logic [3:0] b,
                          output slcr_byte_t q, output int n);
    n = 0;
    @(posedge ref_clk);
    addr  <= {ix, lo};
    rd    <= ~is_wr;
    wr    <= is_wr;
    wdata <= {24'h00_0000, d};
    be    <= b;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wait_req !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr_reg(input slcr_idx_t ix, input slcr_byte_t d);
    bus_xfer(1'b1, ix, 2'b00, d, 4'h1, got, cyc);
  endtask

  task automatic rd_chk(input slcr_idx_t ix, input slcr_byte_t e);
    bus_xfer(1'b0, ix, 2'b00, 8'h00, 4'h1, got, cyc);
    `CHK(got, e)
  endtask

  task automatic chk_out(input slcr_byte_t pd_e, input slcr_sel_t s0, input slcr_sel_t s1);
    @(negedge ref_clk);
    `CHK(pd, pd_e)
    `CHK(sel0, s0)
    `CHK(sel1, s1)
    `CHK(hot0, ONEHOT_BASE << s0)
    `CHK(hot1, ONEHOT_BASE << s1)
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    addr = 14'h0000;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0000_0000;
    be = 4'h0;
    n_mismatch = 0;
    checks_done = 0;
    // parameter sum of 0xc3 puts each checksum on its documented reset value
    for (i = 0; i < PARAM_CNT; i++) params[i] = 8'h10;
    params[0] = 8'h13;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    chk_out(8'h00, 3'h0, 3'h1);
    rd_chk(IDX_LANE_PD, 8'h00);
    rd_chk(IDX_XBAR_A, 8'h10);
    for (i = 0; i < CKSUM_CNT; i++) begin
      idx = IDX_CKSUM0 + 12'(i);
      rd_chk(idx, slcr_byte_t'(8'hC3 + i));
    end
    // sum of 0xb40 must wrap to 0x40
    for (i = 0; i < PARAM_CNT; i++) params[i] <= 8'hF0;
    for (i = 0; i < CKSUM_CNT; i++) begin
      idx = IDX_CKSUM0 + 12'(i);
      wr_reg(idx, 8'h00);
      rd_chk(idx, slcr_byte_t'(8'h40 + i));
    end
    for (i = 0; i < LANE_CNT; i++) begin
      wr_reg(IDX_LANE_PD, ONEHOT_BASE << i);
      chk_out(ONEHOT_BASE << i, 3'h0, 3'h1);
      rd_chk(IDX_LANE_PD, ONEHOT_BASE << i);
    end
    wr_reg(IDX_LANE_PD, 8'hFF);
    // byte lane 0 off, then a misaligned address: neither may store
    bus_xfer(1'b1, IDX_LANE_PD, 2'b00, 8'h00, 4'hE, got, cyc);
    bus_xfer(1'b1, IDX_LANE_PD, 2'b01, 8'h00, 4'h1, got, cyc);
    rd_chk(IDX_LANE_PD, 8'hFF);
    rd_chk(12'h05B1, 8'h00);
    for (i = 0; i < LANE_CNT; i++) begin
      wr_reg(IDX_XBAR_A, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
      chk_out(8'hFF, 3'(7 - i), 3'(i));
      rd_chk(IDX_XBAR_A, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
    end
    // clock enable low must stall the answer, not lose it
    ce <= 1'b0;
    fork
      bus_xfer(1'b0, IDX_LANE_PD, 2'b00, 8'h00, 4'h1, got, cyc);
      begin
        repeat (6) @(posedge ref_clk);
        ce <= 1'b1;
      end
    join
    `CHK(got, 8'hFF)
    `CHK(cyc > 5, 1'b1)
    // second reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    chk_out(8'h00, 3'h0, 3'h1);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    rd_chk(IDX_XBAR_A, 8'h10);
    give_verdict();
  end
endmodule
`undef CHK
`default_nettype wire
